// File: hdl/cpu_interrupt_prioritizer.sv
// Interrupt prioritizer between peripheral requests and the processor core
//
// Behaviour
// - Grant only when outranking the running level
// - One program instruction after return before servicing
// - Maskable requests need global enable set
// - Servicing never clears the peripheral flag
// - Finish one, push two, jump three/two
// - Multi-cycle instruction completes before response starts
// - Wake from sleep adds five after start-up
// - Return takes four or five cycles
// - High level preempts normal; normal resumes later
// - Non-maskable ignores and never changes enable
// - Nothing preempts a running non-maskable handler
// - Lowest non-maskable vector number wins
// - Non-maskable sources fixed, still need enabling
// - High-level vector register promotes one request
// - Other maskable vectors stay at normal level
// - Index zero reset, index one non-maskable
// - Reset, non-maskable, high outrank all normal
// - Static scheme: lowest normal vector first
// - Lowest-priority register rotates the normal order
// - Vector base follows location select unless all flash is boot
// - Select low after boot, high at boot start
// - Rotating mode stores last taken normal vector
// - Compact table uses vectors one, two, three
`timescale 1ns/1ps
module cpu_interrupt_prioritizer
  import irq_prio_pkg::*;
#(
  parameter int NUM_VEC = 32,
  parameter int ADDR_W = 16,
  parameter logic [NUM_VEC-1:0] NMI_MASK = {{(NUM_VEC-2){1'b0}}, 2'b10},
  parameter bit FLASH_ABOVE_8K = 1'b1,
  parameter bit PC_WIDE = 1'b0
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Peripheral request levels, one per vector number
  input wire logic [NUM_VEC-1:0] irq_req_in,
  // Core status and handshakes
  input wire logic global_enable_in,
  input wire logic instr_done_in,
  input wire logic sleeping_in,
  input wire logic wake_ready_in,
  input wire logic return_in,
  // Static configuration
  input wire logic vector_location_select_in,
  input wire logic compact_table_enable_in,
  input wire logic rotating_priority_enable_in,
  input wire logic all_flash_boot_in,
  input wire logic [ADDR_W-1:0] boot_end_in,
  // Priority register writes
  input wire logic high_level_vector_wr_in,
  input wire logic [VEC_W-1:0] high_level_vector_data_in,
  input wire logic normal_priority_wr_in,
  input wire logic [VEC_W-1:0] normal_priority_data_in,
  // Register readback and executing flags
  output logic [VEC_W-1:0] high_level_vector_out,
  output logic [VEC_W-1:0] normal_lowest_priority_out,
  output logic nmi_exec_out,
  output logic high_exec_out,
  output logic normal_exec_out,
  // Response sequence to the core
  output logic take_out,
  output logic stall_core_out,
  output logic push_pc_out,
  output logic pop_pc_out,
  output logic handler_entry_out,
  output logic [VEC_W-1:0] vector_index_out,
  output logic [ADDR_W-1:0] vector_addr_out
);

  // Refuse sizes the logic cannot serve
  initial begin
    if (NUM_VEC < 3 || NUM_VEC > (1 << VEC_W)) begin
      $error("cpu_interrupt_prioritizer: NUM_VEC out of range");
    end
    if (NMI_MASK[RESET_VEC] || !NMI_MASK[NMI_VEC]) begin
      $error("cpu_interrupt_prioritizer: NMI_MASK must hold vector one, not zero");
    end
  end

  // Phase lengths that depend on flash size and program counter width
  localparam logic [CNT_W-1:0] JUMP_CYC = FLASH_ABOVE_8K ? JUMP_CYCLES_LONG : JUMP_CYCLES_SHORT;
  localparam logic [CNT_W-1:0] RET_CYC = PC_WIDE ? RET_CYCLES_WIDE : RET_CYCLES_NARROW;
  // Vector zero is reset and never a request source
  localparam logic [NUM_VEC-1:0] SRC_MASK = {{(NUM_VEC-1){1'b1}}, 1'b0};
  // Rotation point that makes vector zero lowest, so vector one ranks first
  localparam logic [VEC_W-1:0] FIXED_LAST = 8'h00;

  // Sequencer state and its next value
  seq_state_type state_reg;
  seq_state_type state_next;
  // Priority registers
  logic [VEC_W-1:0] high_level_vector_reg;
  logic [VEC_W-1:0] normal_lowest_priority_reg;
  // Executing flags, one per level
  logic nmi_exec_reg;
  logic high_exec_reg;
  logic normal_exec_reg;
  // Captured winner of the current response
  level_type taken_level_reg;
  logic [VEC_W-1:0] taken_index_reg;
  logic [VEC_W-1:0] vector_index_reg;
  logic [ADDR_W-1:0] vector_addr_reg;
  // Request sorting
  logic [NUM_VEC-1:0] high_bit;
  logic [NUM_VEC-1:0] nmi_req;
  logic [NUM_VEC-1:0] high_req;
  logic [NUM_VEC-1:0] normal_req;
  logic nmi_found;
  logic [VEC_W-1:0] nmi_index;
  logic normal_found;
  logic [VEC_W-1:0] normal_index;
  // Eligibility after level comparison
  logic nmi_ok;
  logic high_ok;
  logic normal_ok;
  logic win_ok;
  level_type win_level;
  logic [VEC_W-1:0] win_index;
  // Phase timer control
  logic timer_load;
  logic [CNT_W-1:0] timer_count;
  logic timer_done;
  // Vector address terms
  logic [VEC_W-1:0] table_index;
  logic [ADDR_W-1:0] table_base;

  // One-hot decode of the high-level vector register
  generate
    for (genvar i = 0; i < NUM_VEC; i++) begin : g_high
      assign high_bit[i] = (high_level_vector_reg == VEC_W'(i));
    end
  endgenerate

  // Sort live request levels into the three priority levels
  assign nmi_req = irq_req_in & NMI_MASK & SRC_MASK;
  assign high_req = irq_req_in & high_bit & ~NMI_MASK & SRC_MASK;
  assign normal_req = irq_req_in & ~high_bit & ~NMI_MASK & SRC_MASK;

  // Fixed order among non-maskable sources
  rotating_arbiter #(
    .N(NUM_VEC),
    .W(VEC_W)
  ) u_nmi_arb (
    .req_in(nmi_req),
    .last_in(FIXED_LAST),
    .found_out(nmi_found),
    .index_out(nmi_index)
  );

  // Normal order starts just after the lowest-priority register
  rotating_arbiter #(
    .N(NUM_VEC),
    .W(VEC_W)
  ) u_normal_arb (
    .req_in(normal_req),
    .last_in(normal_lowest_priority_reg),
    .found_out(normal_found),
    .index_out(normal_index)
  );

  // Compare each level against the running handler, maskable levels also against global enable
  assign nmi_ok = nmi_found && !nmi_exec_reg;
  assign high_ok = (high_req != '0) && global_enable_in
                   && !nmi_exec_reg && !high_exec_reg;
  assign normal_ok = normal_found && global_enable_in
                     && !nmi_exec_reg && !high_exec_reg && !normal_exec_reg;
  assign win_ok = nmi_ok || high_ok || normal_ok;

  // Pick the winning level, non-maskable first, normal last
  always_comb begin
    win_level = LVL_NORMAL;
    win_index = normal_index;
    if (nmi_ok) begin
      win_level = LVL_NMI;
      win_index = nmi_index;
    end else if (high_ok) begin
      win_level = LVL_HIGH;
      win_index = high_level_vector_reg;
    end
  end

  // Phase timer for the fixed-length steps
  phase_timer u_timer (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .load_in(timer_load),
    .count_in(timer_count),
    .done_out(timer_done)
  );

  // Next state and timer loads of the response and return sequences
  always_comb begin
    state_next = state_reg;
    timer_load = 1'b0;
    timer_count = FINISH_CYCLES;
    case (state_reg)
      S_IDLE: begin
        if (return_in) begin
          state_next = S_RET;
          timer_load = 1'b1;
          timer_count = RET_CYC;
        end else if (win_ok && sleeping_in) begin
          state_next = S_SLEEP;
        end else if (win_ok) begin
          state_next = S_FINISH;
        end
      end
      S_SLEEP: begin
        // Wait out the start-up time of the sleep mode
        if (wake_ready_in) begin
          state_next = S_WAKE;
          timer_load = 1'b1;
          timer_count = WAKE_EXTRA_CYCLES;
        end
      end
      S_WAKE: begin
        if (timer_done) begin
          state_next = S_PUSH;
          timer_load = 1'b1;
          timer_count = PUSH_CYCLES;
        end
      end
      S_FINISH: begin
        // Hold until the ongoing instruction completes
        if (instr_done_in) begin
          state_next = S_PUSH;
          timer_load = 1'b1;
          timer_count = PUSH_CYCLES;
        end
      end
      S_PUSH: begin
        if (timer_done) begin
          state_next = S_JUMP;
          timer_load = 1'b1;
          timer_count = JUMP_CYC;
        end
      end
      S_JUMP: begin
        if (timer_done) begin
          state_next = S_IDLE;
        end
      end
      S_RET: begin
        if (timer_done) begin
          state_next = S_GAP;
        end
      end
      S_GAP: begin
        // One instruction of the resumed program runs first
        if (instr_done_in) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Capture the winner when the response begins
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      taken_level_reg <= LVL_NORMAL;
      taken_index_reg <= '0;
    end else if (take_out) begin
      taken_level_reg <= win_level;
      taken_index_reg <= win_index;
    end
  end

  // High-level vector register, written by software only
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      high_level_vector_reg <= HIGH_VEC_RESET;
    end else if (high_level_vector_wr_in) begin
      high_level_vector_reg <= high_level_vector_data_in;
    end
  end

  // Lowest-priority register; a hardware update wins over a software write
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      normal_lowest_priority_reg <= NORMAL_PRI_RESET;
    end else if (take_out && win_level == LVL_NORMAL && rotating_priority_enable_in) begin
      normal_lowest_priority_reg <= win_index;
    end else if (normal_priority_wr_in) begin
      normal_lowest_priority_reg <= normal_priority_data_in;
    end
  end

  // Executing flags: set on handler entry, innermost cleared on return
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      nmi_exec_reg <= 1'b0;
      high_exec_reg <= 1'b0;
      normal_exec_reg <= 1'b0;
    end else if (handler_entry_out) begin
      case (taken_level_reg)
        LVL_NMI: nmi_exec_reg <= 1'b1;
        LVL_HIGH: high_exec_reg <= 1'b1;
        default: normal_exec_reg <= 1'b1;
      endcase
    end else if (state_reg == S_RET && timer_done) begin
      if (nmi_exec_reg) begin
        nmi_exec_reg <= 1'b0;
      end else if (high_exec_reg) begin
        high_exec_reg <= 1'b0;
      end else begin
        normal_exec_reg <= 1'b0;
      end
    end
  end

  // Table slot: shared slots in compact mode, else the vector number
  always_comb begin
    table_index = taken_index_reg;
    if (compact_table_enable_in) begin
      case (taken_level_reg)
        LVL_NMI: table_index = COMPACT_NMI_VEC;
        LVL_HIGH: table_index = COMPACT_HIGH_VEC;
        default: table_index = COMPACT_NORMAL_VEC;
      endcase
    end
  end

  // Table base: boot start when selected or when all flash is boot
  assign table_base = (vector_location_select_in || all_flash_boot_in)
                      ? '0 : boot_end_in;

  // Vector outputs, loaded as the push begins; two words per slot above 8 KB
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      vector_index_reg <= '0;
      vector_addr_reg <= '0;
    end else if (timer_load && timer_count == PUSH_CYCLES) begin
      vector_index_reg <= table_index;
      vector_addr_reg <= table_base
                         + (ADDR_W'(table_index) << (FLASH_ABOVE_8K ? 1 : 0));
    end
  end

  // Handshake and status outputs
  assign take_out = (state_reg == S_IDLE) && !return_in && win_ok;
  assign push_pc_out = (state_reg == S_PUSH);
  assign pop_pc_out = (state_reg == S_RET);
  assign handler_entry_out = (state_reg == S_JUMP) && timer_done;
  assign stall_core_out = (state_reg == S_PUSH) || (state_reg == S_JUMP)
                          || (state_reg == S_RET) || (state_reg == S_WAKE);
  assign high_level_vector_out = high_level_vector_reg;
  assign normal_lowest_priority_out = normal_lowest_priority_reg;
  assign nmi_exec_out = nmi_exec_reg;
  assign high_exec_out = high_exec_reg;
  assign normal_exec_out = normal_exec_reg;
  assign vector_index_out = vector_index_reg;
  assign vector_addr_out = vector_addr_reg;

  // Cycles spent in the current state, for the checks below
  logic [3:0] stay_cnt_reg;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      stay_cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      stay_cnt_reg <= '0;
    end else if (stay_cnt_reg != 4'hF) begin
      stay_cnt_reg <= stay_cnt_reg + 4'h1;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Push lasts exactly two cycles, then the jump follows
  sequence push_phase_s;
    (state_reg == S_PUSH) [*2];
  endsequence
  push_len_a: assert property (
    $rose(state_reg == S_PUSH) |-> push_phase_s ##1 (state_reg == S_JUMP))
    else $error("push phase is not two cycles");

  // Jump lasts three or two cycles by flash size
  jump_len_a: assert property (
    (state_reg == S_JUMP && state_next != S_JUMP) |-> (stay_cnt_reg == 4'(JUMP_CYC) - 4'h1))
    else $error("jump phase has wrong length");

  // Return lasts four or five cycles, then waits for one instruction
  ret_len_a: assert property (
    (state_reg == S_RET && state_next != S_RET)
      |-> (stay_cnt_reg == 4'(RET_CYC) - 4'h1) ##1 (state_reg == S_GAP))
    else $error("return phase has wrong length");

  // Wake adds five cycles before the push
  sequence wake_phase_s;
    (state_reg == S_WAKE) [*5];
  endsequence
  wake_len_a: assert property (
    $rose(state_reg == S_WAKE) |-> wake_phase_s ##1 (state_reg == S_PUSH))
    else $error("wake extension is not five cycles");

  // No new response while a non-maskable handler runs
  nmi_block_a: assert property (
    (nmi_exec_reg && state_reg == S_IDLE)
      |-> !take_out ##1 (state_reg == S_IDLE || state_reg == S_RET))
    else $error("request taken during non-maskable handler");

  // Gap holds until an instruction of the program completes
  gap_hold_a: assert property (
    (state_reg == S_GAP && !instr_done_in) |=> (state_reg == S_GAP))
    else $error("request serviced before one instruction ran");

  // Finish holds until the ongoing instruction completes
  finish_wait_a: assert property (
    (state_reg == S_FINISH && !instr_done_in) |=> (state_reg == S_FINISH))
    else $error("response began inside an instruction");

  // Maskable takes need the global enable
  mask_gate_a: assert property (
    (take_out && win_level != LVL_NMI) |-> global_enable_in)
    else $error("maskable request taken with global enable low");

  // Rotating mode records the taken normal vector
  rotate_store_a: assert property (
    (take_out && win_level == LVL_NORMAL && rotating_priority_enable_in)
      |=> (normal_lowest_priority_reg == $past(win_index)))
    else $error("last taken normal vector not stored");

  // High level outranks a running normal handler
  high_preempt_a: assert property (
    (state_reg == S_IDLE && !return_in && high_ok && !nmi_ok)
      |-> (take_out && win_level == LVL_HIGH))
    else $error("high level did not preempt");

endmodule : cpu_interrupt_prioritizer

// File: hdl/irq_prio_pkg.sv
// Shared constants and types for the processor interrupt prioritizer
package irq_prio_pkg;

  // Width of a vector number and of the two priority registers
  localparam int VEC_W = 8;

  // Fixed vector numbers: reset and the non-maskable vector
  localparam int RESET_VEC = 0;
  localparam int NMI_VEC = 1;

  // Vector numbers used when the compact table is enabled
  localparam logic [VEC_W-1:0] COMPACT_NMI_VEC = 8'h01;
  localparam logic [VEC_W-1:0] COMPACT_HIGH_VEC = 8'h02;
  localparam logic [VEC_W-1:0] COMPACT_NORMAL_VEC = 8'h03;

  // Reset values of the priority registers
  localparam logic [VEC_W-1:0] HIGH_VEC_RESET = 8'h00;
  localparam logic [VEC_W-1:0] NORMAL_PRI_RESET = 8'h00;

  // Cycle counts of the response and return sequences
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] FINISH_CYCLES = 3'h1;
  localparam logic [CNT_W-1:0] PUSH_CYCLES = 3'h2;
  localparam logic [CNT_W-1:0] JUMP_CYCLES_LONG = 3'h3;
  localparam logic [CNT_W-1:0] JUMP_CYCLES_SHORT = 3'h2;
  localparam logic [CNT_W-1:0] WAKE_EXTRA_CYCLES = 3'h5;
  localparam logic [CNT_W-1:0] RET_CYCLES_NARROW = 3'h4;
  localparam logic [CNT_W-1:0] RET_CYCLES_WIDE = 3'h5;

  // Sequencer states, Gray coded along idle, finish, push, jump
  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_FINISH = 3'h1,
    S_PUSH   = 3'h3,
    S_JUMP   = 3'h2,
    S_GAP    = 3'h6,
    S_RET    = 3'h7,
    S_SLEEP  = 3'h5,
    S_WAKE   = 3'h4
  } seq_state_type;

  // Priority level of a taken request
  typedef enum logic [1:0] {
    LVL_NORMAL = 2'h0,
    LVL_HIGH   = 2'h1,
    LVL_NMI    = 2'h2
  } level_type;

endpackage : irq_prio_pkg

// File: hdl/rotating_arbiter.sv
// Circular first-set search starting just after a given index
`timescale 1ns/1ps
module rotating_arbiter
  import irq_prio_pkg::*;
#(
  parameter int N = 32,
  parameter int W = 8
) (
  // Request vector and rotation point
  input wire logic [N-1:0] req_in,
  input wire logic [W-1:0] last_in,
  // Winner
  output logic found_out,
  output logic [W-1:0] index_out
);

  // Refuse sizes the index cannot address
  initial begin
    if (N < 2 || N > (1 << W)) begin
      $error("rotating_arbiter: N does not fit index width");
    end
  end

  // Walk from the lowest-ranked offset down so the highest-ranked hit is kept
  always_comb begin
    int pos;
    pos = 0;
    found_out = 1'b0;
    index_out = '0;
    for (int k = N - 1; k >= 0; k--) begin
      pos = (int'(last_in) + 1 + k) % N;
      if (req_in[pos]) begin
        found_out = 1'b1;
        index_out = W'(pos);
      end
    end
  end

endmodule : rotating_arbiter

// File: hdl/phase_timer.sv
// Loadable down-counter that marks the last cycle of a timed phase
`timescale 1ns/1ps
module phase_timer
  import irq_prio_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Load request with phase length in cycles
  input wire logic load_in,
  input wire logic [CNT_W-1:0] count_in,
  // High in the last cycle of the phase
  output logic done_out
);

  // Remaining cycles of the current phase
  logic [CNT_W-1:0] cnt_reg;

  // Load on phase entry, then count down to zero
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
    end else if (load_in) begin
      cnt_reg <= count_in;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Phase ends when one cycle remains
  assign done_out = (cnt_reg == CNT_W'(1));

endmodule : phase_timer

// File: verif/core_model.sv
// Peripheral condition flags and core instruction timing facing the prioritizer
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Flag set, clear and line enables
  input wire logic [31:0] set_in,
  input wire logic [31:0] clr_in,
  input wire logic [31:0] en_in,
  // Cycles per instruction, at least one
  input wire logic [2:0] instr_len_in,
  // Toward the prioritizer
  output logic [31:0] irq_req_out,
  output logic instr_done_out
);
  logic [31:0] flag_reg; // Condition flags
  logic [2:0] left_reg; // Cycles left in the running instruction
  // Flags stay set until their own clear, whatever the core services
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) flag_reg <= 32'h0;
    else flag_reg <= (flag_reg | set_in) & ~clr_in;
  end
  // Only enabled lines with an occurred condition raise a request
  assign irq_req_out = flag_reg & en_in;
  // Instruction length counter
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) left_reg <= 3'h0;
    else if (left_reg == 3'h0) left_reg <= instr_len_in - 3'h1;
    else left_reg <= left_reg - 3'h1;
  end
  // Last cycle of each instruction
  assign instr_done_out = (left_reg == 3'h0);
endmodule : core_model

// File: verif/cpu_interrupt_prioritizer_tb.sv
// Self-checking bench for the interrupt prioritizer
`timescale 1ns/1ps
module cpu_interrupt_prioritizer_tb;
  import irq_prio_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [31:0] set_v = 32'h0, clr_v = 32'h0, en_v = 32'hFFFFFFFE, irq_req, flags = 32'h0;
  logic [2:0] len_v = 3'h1; // Instruction length
  logic ge = 1'b1, done, slp = 1'b0, wrdy = 1'b0, ret_v = 1'b0;
  logic vls = 1'b0, compact_table_enable = 1'b0, rr = 1'b0, afb = 1'b0, hw = 1'b0, nw = 1'b0;
  logic [15:0] boot_end = 16'h0400, va;
  logic [7:0] hd = 8'h00, nd = 8'h00, hv, lo, vi, hl_e = 8'h00, lo_e = 8'h00;
  logic nx, hx, lx, tk, st, pu, po, he;
  int mismatches = 0, samples_checked = 0, seed = 11, t, p;
  // Clock, 100 ns period
  always #50 mclk_in = ~mclk_in;
  core_model u_model (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .set_in(set_v),
    .clr_in(clr_v), .en_in(en_v), .instr_len_in(len_v), .irq_req_out(irq_req),
    .instr_done_out(done));
  cpu_interrupt_prioritizer u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .irq_req_in(irq_req), .global_enable_in(ge), .instr_done_in(done), .sleeping_in(slp),
    .wake_ready_in(wrdy), .return_in(ret_v), .vector_location_select_in(vls),
    .compact_table_enable_in(compact_table_enable), .rotating_priority_enable_in(rr),
    .all_flash_boot_in(afb), .boot_end_in(boot_end), .high_level_vector_wr_in(hw),
    .high_level_vector_data_in(hd), .normal_priority_wr_in(nw),
    .normal_priority_data_in(nd), .high_level_vector_out(hv),
    .normal_lowest_priority_out(lo), .nmi_exec_out(nx), .high_exec_out(hx),
    .normal_exec_out(lx), .take_out(tk), .stall_core_out(st), .push_pc_out(pu),
    .pop_pc_out(po), .handler_entry_out(he), .vector_index_out(vi), .vector_addr_out(va));
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Expected winner: non-maskable, then high, then normal rotated after lo_e
  function automatic logic [7:0] pick(input logic [31:0] r);
    logic [7:0] k;
    if (r[1]) return 8'h01;
    if (hl_e != 8'h00 && r[hl_e[4:0]]) return hl_e;
    for (int i = 1; i <= 32; i++) begin
      k = 8'((lo_e + i) % 32);
      if (k > 8'h01 && r[k[4:0]]) return k;
    end
    return 8'hFF;
  endfunction : pick
  // Expected handler address of a slot
  function automatic logic [15:0] vaddr(input logic [7:0] s);
    return ((vls | afb) ? 16'h0000 : boot_end) + {7'h00, s, 1'b0};
  endfunction : vaddr
  // Set and clear peripheral flags for one cycle
  task automatic pulse(input logic [31:0] s, input logic [31:0] c);
    @(posedge mclk_in);
    set_v <= s;
    clr_v <= c;
    flags = (flags | s) & ~c;
    @(posedge mclk_in);
    set_v <= 32'h0;
    clr_v <= 32'h0;
  endtask : pulse
  // Write a priority register and read it back
  task automatic wrv(input bit hi, input logic [7:0] v);
    @(posedge mclk_in);
    if (hi) begin
      hw <= 1'b1;
      hd <= v;
      hl_e = v;
    end else begin
      nw <= 1'b1;
      nd <= v;
      lo_e = v;
    end
    @(posedge mclk_in);
    hw <= 1'b0;
    nw <= 1'b0;
    @(negedge mclk_in);
    chk(hi ? hv : lo, v);
  endtask : wrv
  // Count takes and pop cycles over n cycles
  task automatic watch(input int n, output int tt, output int pp);
    tt = 0;
    pp = 0;
    repeat (n) begin
      @(negedge mclk_in);
      tt += int'(tk === 1'b1);
      pp += int'(po === 1'b1);
    end
  endtask : watch
  // Await a take, then time the response and check the vector
  task automatic serve(input logic [7:0] idx, input logic [7:0] slot, input bit zz, input int ext);
    int n, b;
    logic pd, first;
    n = 0;
    first = 1'b1;
    b = int'(PUSH_CYCLES) + int'(JUMP_CYCLES_LONG) + (zz ? 1 + int'(WAKE_EXTRA_CYCLES) : int'(FINISH_CYCLES));
    do begin
      @(negedge mclk_in);
      n++;
    end while (tk !== 1'b1 && n < 60);
    chk(tk, 1'b1);
    if (zz) @(posedge mclk_in) wrdy <= 1'b1;
    n = 0;
    while (he !== 1'b1 && n < 40) begin
      pd = done;
      @(negedge mclk_in);
      n++;
      if (pu === 1'b1 && first) begin
        first = 1'b0;
        chk({pd | zz, st}, 2'b11);
      end
    end
    chk(n >= b && n <= b + ext, 1'b1);
    chk(vi, compact_table_enable ? slot : idx);
    chk(va, vaddr(slot));
    if (zz) begin
      @(posedge mclk_in);
      wrdy <= 1'b0;
      slp <= 1'b0;
    end
  endtask : serve
  // Return from handler: pop cycles, no take before one instruction
  task automatic ret_seq();
    @(posedge mclk_in) ret_v <= 1'b1;
    @(posedge mclk_in) ret_v <= 1'b0;
    watch(5, t, p);
    chk(p, RET_CYCLES_NARROW);
    chk(t, 0);
  endtask : ret_seq
  // Serve every pending flag in expected order
  task automatic drain(input bit zz, input int ext);
    logic [7:0] w;
    while (flags != 32'h0) begin
      w = pick(flags);
      // The core may already sleep when the first request of a batch arrives
      if (zz && !slp) @(posedge mclk_in) slp <= 1'b1;
      serve(w, compact_table_enable ? (w == 8'h01 ? 8'h01 : (w == hl_e ? 8'h02 : 8'h03)) : w, zz, ext);
      if (rr && w != hl_e && w != 8'h01) lo_e = w;
      pulse(32'h0, 32'h1 << w);
      ret_seq();
      chk(lo, lo_e);
    end
  endtask : drain
  // Report counts and verdict, then stop
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // Watchdog, far beyond the expected run length
  initial begin
    #5000000;
    mismatches++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(negedge mclk_in);
    chk({hv, lo}, {HIGH_VEC_RESET, NORMAL_PRI_RESET});
    // Random requests, static then modified and rotating order
    for (int j = 0; j < 6; j++) begin
      if (j == 2) wrv(1'b0, 8'($random(seed) & 31));
      if (j == 3) wrv(1'b1, 8'h02 + 8'($random(seed) & 15));
      if (j == 4) @(posedge mclk_in) rr <= 1'b1;
      pulse($random(seed) & $random(seed) & 32'hFFFFFFFC, 32'h0);
      drain(1'b0, 0);
    end
    $display("Test priority order done");
    // High level preempts a running normal handler
    wrv(1'b1, 8'h07);
    pulse(32'h1 << 20, 32'h0);
    serve(8'd20, 8'd20, 1'b0, 0);
    pulse(32'h1 << 7, 32'h0);
    serve(8'd7, 8'd7, 1'b0, 0);
    @(negedge mclk_in) chk({hx, lx}, 2'b11);
    pulse(32'h0, 32'h1 << 7);
    ret_seq();
    chk({hx, lx}, 2'b01);
    pulse(32'h0, 32'h1 << 20);
    ret_seq();
    chk(lx, 1'b0);
    $display("Test preemption done");
    // Masking, non-maskable entry and its protection
    @(posedge mclk_in) ge <= 1'b0;
    pulse(32'h1 << 20, 32'h0);
    watch(20, t, p);
    chk(t, 0);
    pulse(32'h2, 32'h0);
    serve(8'h01, 8'h01, 1'b0, 0);
    @(posedge mclk_in) ge <= 1'b1;
    pulse(32'h1 << 7, 32'h0);
    watch(20, t, p);
    chk({t[7:0], nx}, 9'h001);
    pulse(32'h0, 32'h2);
    ret_seq();
    lo_e = 8'd20;
    drain(1'b0, 0);
    $display("Test masking done");
    // Multi-cycle instructions, then wake from sleep
    @(posedge mclk_in) len_v <= 3'h3;
    pulse(32'h0000_1230, 32'h0);
    drain(1'b0, 2);
    @(posedge mclk_in) len_v <= 3'h1;
    slp <= 1'b1;
    pulse(32'h0041_0008, 32'h0);
    drain(1'b1, 0);
    $display("Test timing done");
    // Compact table at the boot-start base, by location select then by all-flash boot
    @(posedge mclk_in) compact_table_enable <= 1'b1;
    vls <= 1'b1;
    pulse(32'h0000_0284 | (32'h1 << 7), 32'h0);
    drain(1'b0, 0);
    @(posedge mclk_in) vls <= 1'b0;
    afb <= 1'b1;
    pulse(32'h0010_0002, 32'h0);
    drain(1'b0, 0);
    $display("Test vector table done");
    wrap_up();
  end
endmodule : cpu_interrupt_prioritizer_tb
